/* File: core/pmr_regs.svh */
/*
 * Register map, field positions, reset values and timing figures of the
 * power monitor result datapath.
 * Assumes byte addressing on an APB bus with 32-bit data.
 */
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

// Register byte offsets
`define PMR_OFS_CONFIG 8'h00
`define PMR_OFS_CAL 8'h04
`define PMR_OFS_SHUNT 8'h08
`define PMR_OFS_BUS 8'h0C
`define PMR_OFS_TEMP 8'h10
`define PMR_OFS_CURRENT 8'h14
`define PMR_OFS_POWER 8'h18
`define PMR_OFS_STATUS 8'h1C
`define PMR_OFS_ID 8'h20

// Config fields and reset values
`define PMR_CFG_RANGE 0
`define PMR_CFG_CT_LSB 1
`define PMR_CFG_AVG_LSB 4
`define PMR_CFG_EN 7
`define PMR_CFG_RST 8'h8A
`define PMR_STAT_READY 0

// Clock rate in MHz
`define PMR_CLK_MHZ 100

// Conversion times in microseconds
`define PMR_CT0_US 13'h0032
`define PMR_CT1_US 13'h0054
`define PMR_CT2_US 13'h0096
`define PMR_CT3_US 13'h0118
`define PMR_CT4_US 13'h021C
`define PMR_CT5_US 13'h041C
`define PMR_CT6_US 13'h081A
`define PMR_CT7_US 13'h1018

// Averaging as a shift: 1,4,16,64,128,256,512,1024 samples
`define PMR_AVG0_SH 4'h0
`define PMR_AVG1_SH 4'h2
`define PMR_AVG2_SH 4'h4
`define PMR_AVG3_SH 4'h6
`define PMR_AVG4_SH 4'h7
`define PMR_AVG5_SH 4'h8
`define PMR_AVG6_SH 4'h9
`define PMR_AVG7_SH 4'hA

// Arithmetic scaling shifts
`define PMR_CUR_SHIFT 11
`define PMR_PWR_SHIFT 6

`endif

/* File: core/pmr_pkg.sv */
/*
 * Types shared by the power monitor result datapath.
 * Assumes pmr_regs.svh for numeric constants.
 */
package pmr_pkg;

    typedef enum logic [2:0] {
        PMR_IDLE = 3'b001,
        PMR_CONV = 3'b010,
        PMR_CALC = 3'b100
    } pmr_seq_type;

    typedef struct packed {
        pmr_seq_type seq;
        logic [7:0] cfg;
        logic [15:0] cal;
        logic [15:0] shunt;
        logic [14:0] bus;
        logic [11:0] temp;
        logic [15:0] current;
        logic [23:0] power;
        logic ready;
        logic signed [25:0] acc_sh;
        logic [24:0] acc_bus;
        logic signed [21:0] acc_tp;
        logic [10:0] navg;
        logic calc_go;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pmr_top_st_type;

    typedef struct packed {
        logic [19:0] cnt;
        logic done;
    } pmr_tmr_st_type;

    typedef struct packed {
        logic busy;
        logic [15:0] current;
        logic [23:0] power;
        logic done;
    } pmr_calc_st_type;

endpackage

/* File: core/pmr_calc_if.sv */
/*
 * Link between the result sequencer and the current/power arithmetic.
 * Assumes both ends run on i_clk_sys; start is a one-cycle pulse.
 */
`timescale 1ns/1ps
interface pmr_calc_if;
    logic start;
    logic [15:0] shunt;
    logic [14:0] bus;
    logic [15:0] cal;
    logic done;
    logic [15:0] current;
    logic [23:0] power;
    modport calc(input start, shunt, bus, cal, output done, current, power);
    modport seq(output start, shunt, bus, cal, input done, current, power);
endinterface

/* File: core/pmr_conv_timer.sv */
/*
 * Conversion timer: one-cycle pulse at the end of every conversion.
 * Assumes i_sel comes from a register on the same clock.
 */
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_conv_timer
    import pmr_pkg::*;
#(
    parameter int unsigned P_CYC_PER_US = `PMR_CLK_MHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic [2:0] i_sel,
    output logic o_done
);
    pmr_tmr_st_type st, next_st;
    logic [19:0] tgt;
    logic [19:0] h_gap;
    logic h_ok;
    logic [2:0] h_sel;

    // Time in microseconds scaled to clock cycles
    function automatic logic [19:0] conv_cycles(input logic [2:0] s);
        logic [12:0] us;
        case (s)
            3'h0: us = `PMR_CT0_US;
            3'h1: us = `PMR_CT1_US;
            3'h2: us = `PMR_CT2_US;
            3'h3: us = `PMR_CT3_US;
            3'h4: us = `PMR_CT4_US;
            3'h5: us = `PMR_CT5_US;
            3'h6: us = `PMR_CT6_US;
            default: us = `PMR_CT7_US;
        endcase
        return 20'(us * P_CYC_PER_US);
    endfunction

    always_comb begin
        tgt = conv_cycles(i_sel);
        next_st.done = i_run && (st.cnt >= tgt - 20'h00001);
        if (!i_run || next_st.done) begin
            next_st.cnt = 20'h00000;
        end else begin
            next_st.cnt = st.cnt + 20'h00001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_done = st.done;

    // Gap between pulses, valid only while the selection held still
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            h_gap <= 20'h00000;
            h_ok <= 1'b0;
            h_sel <= 3'h0;
        end else begin
            h_sel <= i_sel;
            h_gap <= st.done ? 20'h00001 : h_gap + 20'h00001;
            if (!i_run || i_sel != h_sel) begin
                h_ok <= 1'b0;
            end else if (st.done) begin
                h_ok <= 1'b1;
            end
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    conv_period_a: assert property (
        (o_done && h_ok && i_sel == h_sel) |-> h_gap == tgt
    ) else $error("conversion period differs from selected time");
endmodule

/* File: core/pmr_calc.sv */
/*
 * Current and power arithmetic, two cycles from start to done.
 * Assumes shunt, bus and cal hold steady from start until done.
 */
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_calc
    import pmr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    pmr_calc_if.calc cif
);
    pmr_calc_st_type st, next_st;
    logic signed [32:0] prod;
    logic signed [32:0] cur_w;
    logic [15:0] mag;
    logic [31:0] pw;

    function automatic logic [15:0] sat16(input logic signed [32:0] v);
        if (v > 33'sh0_0000_7FFF) return 16'h7FFF;
        if (v < -33'sh0_0000_8000) return 16'h8000;
        return v[15:0];
    endfunction

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        prod = $signed(cif.shunt) * $signed({1'b0, cif.cal});
        cur_w = prod >>> `PMR_CUR_SHIFT;
        mag = st.current[15] ? 16'(-st.current) : st.current;
        pw = {16'h0000, mag} * {17'h00000, cif.bus};
        if (cif.start) begin
            next_st.current = sat16(cur_w);
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            next_st.power = (pw[31:30] != 2'h0) ? 24'hFFFFFF : pw[29:6];
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cif.done = st.done;
    assign cif.current = st.current;
    assign cif.power = st.power;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    cal_zero_a: assert property (
        (cif.start && cif.cal == 16'h0000) |-> ##2 (st.done && st.current == 16'h0000)
    ) else $error("zero calibration gave nonzero current");

    power_zero_a: assert property (
        (st.done && (st.current == 16'h0000 || cif.bus == 15'h0000))
            |-> st.power == 24'h000000
    ) else $error("power nonzero with zero current or bus");
endmodule

/* File: core/pmr_top.sv */
/*
 * Result datapath of a shunt power monitor: conversion sequencing,
 * averaging, result registers, current/power and an APB slave.
 * Assumes the sample inputs come from modulator logic on i_clk_sys and
 * are valid in the cycle the conversion timer pulses.
 */
// Local design decisions: the placing of the registers and the APB register port.
// Contract
// - Range bit selects shunt scale
// - Shunt and bus results are 16-bit; the bus result holds 15 bits here, its top bit reads 0
// - Bus result never negative, 3.125 mV step
// - Temperature is signed 12-bit, 125 mdegC step
// - Temperature code spans -256 to +255.875 degC
// - Current recomputed per shunt sample; zero cal
// - Power is unsigned 24-bit result
// - Eight selectable conversion times from 50 us
// - Averaging counts; period is time times count
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_top
    import pmr_pkg::*;
#(
    parameter int unsigned P_CYC_PER_US = `PMR_CLK_MHZ,
    parameter logic [15:0] P_ID = 16'h5A0C // Arbitrary identity value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [15:0] i_adc_shunt,
    input wire logic [14:0] i_adc_bus,
    input wire logic [11:0] i_adc_temp,
    output logic o_range_narrow
);
    localparam pmr_top_st_type ST_RST = '{
        seq: PMR_IDLE,
        cfg: `PMR_CFG_RST,
        default: '0
    };

    pmr_top_st_type st, next_st;
    pmr_calc_if cif();
    logic tmr_done;
    logic [2:0] ct_sel;
    logic [2:0] avg_sel;
    logic [3:0] sh;
    logic [10:0] n_tgt;
    logic enable;
    logic signed [25:0] acc_sh_n;
    logic [24:0] acc_bus_n;
    logic signed [21:0] acc_tp_n;
    logic setup;
    logic xfer;
    logic wr;
    logic rd;
    logic [10:0] h_cnt;
    logic [2:0] h_avg_sel;
    logic h_avg_clean;

    // Every mapped word, read and write alike
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            `PMR_OFS_CONFIG, `PMR_OFS_CAL, `PMR_OFS_SHUNT,
            `PMR_OFS_BUS, `PMR_OFS_TEMP, `PMR_OFS_CURRENT,
            `PMR_OFS_POWER, `PMR_OFS_STATUS, `PMR_OFS_ID: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Averaging count expressed as a power of two
    function automatic logic [3:0] avg_shift(input logic [2:0] s);
        case (s)
            3'h0: return `PMR_AVG0_SH;
            3'h1: return `PMR_AVG1_SH;
            3'h2: return `PMR_AVG2_SH;
            3'h3: return `PMR_AVG3_SH;
            3'h4: return `PMR_AVG4_SH;
            3'h5: return `PMR_AVG5_SH;
            3'h6: return `PMR_AVG6_SH;
            default: return `PMR_AVG7_SH;
        endcase
    endfunction

    // Field taps of the config register
    assign ct_sel = st.cfg[`PMR_CFG_CT_LSB +: 3];
    assign avg_sel = st.cfg[`PMR_CFG_AVG_LSB +: 3];
    assign enable = st.cfg[`PMR_CFG_EN];
    assign sh = avg_shift(avg_sel);
    assign n_tgt = 11'h001 << sh;

    // Timer keeps running through the short arithmetic phase
    pmr_conv_timer #(
        .P_CYC_PER_US(P_CYC_PER_US)
    ) u_tmr (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_run(enable),
        .i_sel(ct_sel),
        .o_done(tmr_done)
    );

    assign cif.start = st.calc_go;
    assign cif.shunt = st.shunt;
    assign cif.bus = st.bus;
    assign cif.cal = st.cal;

    pmr_calc u_calc (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .cif(cif)
    );

    // Next state: bus slave, config writes, sequencer
    always_comb begin
        next_st = st;
        next_st.calc_go = 1'b0;

        // Running sums: shunt and temperature sign-extended, bus zero-extended
        acc_sh_n = st.acc_sh + {{10{i_adc_shunt[15]}}, i_adc_shunt};
        acc_bus_n = st.acc_bus + {10'h000, i_adc_bus};
        acc_tp_n = st.acc_tp + {{10{i_adc_temp[11]}}, i_adc_temp};

        // APB phases: answer one cycle after setup, no wait beyond it
        setup = i_psel && !i_penable;
        xfer = i_psel && i_penable && st.pready;
        wr = xfer && i_pwrite;
        rd = xfer && !i_pwrite;

        next_st.pready = setup;
        next_st.pslverr = setup && !addr_hit(i_paddr);
        next_st.prdata = 32'h0000_0000;
        if (setup && !i_pwrite) begin
            case (i_paddr)
                `PMR_OFS_CONFIG: next_st.prdata = {24'h000000, st.cfg};
                `PMR_OFS_CAL: next_st.prdata = {16'h0000, st.cal};
                `PMR_OFS_SHUNT: next_st.prdata = {16'h0000, st.shunt};
                // top bit of the bus word reads 0
                `PMR_OFS_BUS: next_st.prdata = {17'h00000, st.bus};
                `PMR_OFS_TEMP: next_st.prdata = {20'h00000, st.temp};
                `PMR_OFS_CURRENT: next_st.prdata = {16'h0000, st.current};
                `PMR_OFS_POWER: next_st.prdata = {8'h00, st.power};
                `PMR_OFS_STATUS: next_st.prdata = {31'h00000000, st.ready};
                `PMR_OFS_ID: next_st.prdata = {16'h0000, P_ID};
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end

        // Register writes take effect at the completing edge only
        // range bit steers the front-end gain
        if (wr && i_paddr == `PMR_OFS_CONFIG) begin
            next_st.cfg = i_pwdata[7:0];
        end
        if (wr && i_paddr == `PMR_OFS_CAL) begin
            next_st.cal = i_pwdata[15:0];
        end

        // Clear only a flag the reader actually saw; a later set wins
        if (rd && i_paddr == `PMR_OFS_STATUS && st.prdata[0]) begin
            next_st.ready = 1'b0;
        end

        case (st.seq)
            PMR_IDLE: begin
                // Stopping drops any partial average
                next_st.acc_sh = '0;
                next_st.acc_bus = '0;
                next_st.acc_tp = '0;
                next_st.navg = 11'h000;
                if (enable) begin
                    next_st.seq = PMR_CONV;
                end
            end
            PMR_CONV: begin
                if (!enable) begin
                    next_st.seq = PMR_IDLE;
                end else if (tmr_done) begin
                    if (st.navg + 11'h001 >= n_tgt) begin
                        next_st.shunt = 16'(acc_sh_n >>> sh);
                        next_st.bus = 15'(acc_bus_n >> sh);
                        next_st.temp = 12'(acc_tp_n >>> sh);
                        next_st.acc_sh = '0;
                        next_st.acc_bus = '0;
                        next_st.acc_tp = '0;
                        next_st.navg = 11'h000;
                        next_st.calc_go = 1'b1;
                        next_st.seq = PMR_CALC;
                    end else begin
                        next_st.acc_sh = acc_sh_n;
                        next_st.acc_bus = acc_bus_n;
                        next_st.acc_tp = acc_tp_n;
                        next_st.navg = st.navg + 11'h001;
                    end
                end
            end
            PMR_CALC: begin
                // Pulses here go uncounted; every conversion is far longer
                // derived results follow the new shunt value
                if (cif.done) begin
                    next_st.current = cif.current;
                    next_st.power = cif.power;
                    next_st.ready = 1'b1;
                    next_st.seq = enable ? PMR_CONV : PMR_IDLE;
                end
            end
            default: begin
                next_st.seq = PMR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign o_prdata = st.prdata;
    assign o_pready = st.pready;
    assign o_pslverr = st.pslverr;
    assign o_range_narrow = st.cfg[`PMR_CFG_RANGE];

    // Conversions seen since the last publish, for checking only
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            h_cnt <= 11'h000;
        end else if (st.calc_go || st.seq == PMR_IDLE) begin
            h_cnt <= 11'h000;
        end else if (tmr_done && st.seq == PMR_CONV) begin
            h_cnt <= h_cnt + 11'h001;
        end
    end

    // Averaging choice untouched while samples were gathered
    // A change mid-average is legal, so that window is not checked
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            h_avg_sel <= 3'h0;
            h_avg_clean <= 1'b0;
        end else begin
            h_avg_sel <= avg_sel;
            if (st.seq == PMR_CONV && avg_sel != h_avg_sel) begin
                h_avg_clean <= 1'b0;
            end else if (st.calc_go || st.seq == PMR_IDLE) begin
                h_avg_clean <= 1'b1;
            end
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    range_pin_a: assert property (
        (wr && i_paddr == `PMR_OFS_CONFIG)
            |=> o_range_narrow == $past(i_pwdata[0])
    ) else $error("range output did not follow config write");

    shunt_single_a: assert property (
        (st.seq == PMR_CONV && enable && tmr_done && sh == 4'h0
            && st.navg == 11'h000)
            |=> (st.calc_go && st.shunt == $past(i_adc_shunt))
    ) else $error("unaveraged shunt result not the raw sample");

    bus_msb_a: assert property (
        (o_pready && i_psel && !i_pwrite && i_paddr == `PMR_OFS_BUS)
            |-> o_prdata[31:15] == 17'h00000
    ) else $error("bus result read back with upper bits set");

    temp_single_a: assert property (
        (st.seq == PMR_CONV && enable && tmr_done && sh == 4'h0
            && st.navg == 11'h000)
            |=> st.temp == $past(i_adc_temp)
    ) else $error("unaveraged temperature not the raw sample");

    temp_read_a: assert property (
        (setup && !i_pwrite && i_paddr == `PMR_OFS_TEMP)
            |=> (o_prdata == {20'h00000, $past(st.temp)} && o_pready)
    ) else $error("temperature word read back wrongly");

    calc_follow_a: assert property (
        st.calc_go |-> ##2 cif.done ##1 (st.ready && st.current == $past(cif.current))
    ) else $error("current not refreshed after shunt sample");

    avg_count_a: assert property (
        (st.calc_go && h_avg_clean && $stable(avg_sel)) |-> h_cnt == n_tgt
    ) else $error("published after wrong number of conversions");

    result_hold_a: assert property (
        ($changed(st.shunt) || $changed(st.bus) || $changed(st.temp))
            |-> st.calc_go
    ) else $error("result changed outside an update");

    // Derived results, the new-result flag, the range pin and idle clearing
    flag_set_a: assert property (
        (st.seq == PMR_CALC && cif.done) |=> st.ready
    ) else $error("new-result flag not set after calc");

    zero_current_a: assert property (
        (st.calc_go && st.cal == 16'h0000) |-> ##3 st.current == 16'h0000
    ) else $error("zero calibration gave nonzero current result");

    derived_hold_a: assert property (
        ($changed(st.current) || $changed(st.power)) |-> $past(cif.done)
    ) else $error("current or power changed outside an update");

    range_hold_a: assert property (
        $changed(o_range_narrow)
            |-> ($past(wr) && $past(i_paddr) == `PMR_OFS_CONFIG)
    ) else $error("range output moved without a config write");

    idle_clear_a: assert property (
        (st.seq == PMR_IDLE) |=> (st.navg == 11'h000 && st.acc_sh == '0)
    ) else $error("partial average kept while stopped");

    // Read-back of the wide result words
    shunt_read_a: assert property (
        (setup && !i_pwrite && i_paddr == `PMR_OFS_SHUNT)
            |=> (o_prdata == {16'h0000, $past(st.shunt)} && o_pready)
    ) else $error("shunt word read back wrongly");

    power_read_a: assert property (
        (setup && !i_pwrite && i_paddr == `PMR_OFS_POWER)
            |=> (o_prdata == {8'h00, $past(st.power)} && o_pready)
    ) else $error("power word read back wrongly");
endmodule

/* File: bench/tb.sv */
/*
 * Self-checking bench for the power monitor result datapath.
 * Assumes pmr_top with P_CYC_PER_US = 1, so 1 us is one 10 ns cycle.
 */
`timescale 1ns/1ps
`include "pmr_regs.svh"
module tb
    import pmr_pkg::*;
;
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, narrow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] adc_shunt;
    logic [14:0] adc_bus;
    logic [11:0] adc_temp;
    int miscompares, checks_done;
    int ct_us[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

    // Free running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    pmr_top #(.P_CYC_PER_US(1)) pmr_top_inst (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_adc_shunt(adc_shunt), .i_adc_bus(adc_bus),
        .i_adc_temp(adc_temp), .o_range_narrow(narrow)
    );

    // Verdict and end of run
    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Periods are polled every three cycles, so allow that slack
    task automatic chk_near(input string what, input int exp, input int got);
        checks_done++;
        if (got < exp - 3 || got > exp + 3) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One APB transfer; entered just after a rising edge, idles one cycle
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // Request stands until a rising edge that sees pready high
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        logic err;
        apb(1'b0, a, 32'h0, d, err);
    endtask

    // Poll the new-result flag; reading it as 1 also clears it
    task automatic wait_flag(output realtime t);
        logic [31:0] s;
        for (int i = 0; i < 3000; i++) begin
            reg_rd(`PMR_OFS_STATUS, s);
            if (s[`PMR_STAT_READY] === 1'b1) begin
                t = $realtime;
                return;
            end
        end
        miscompares++;
        close_out();
    endtask

    function automatic logic [15:0] exp_cur(logic [15:0] s, logic [15:0] c);
        longint p;
        p = longint'($signed(s)) * longint'({1'b0, c});
        p = p >>> 11;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction

    function automatic logic [23:0] exp_pwr(logic [15:0] i, logic [14:0] b);
        longint a;
        a = longint'($signed(i));
        if (a < 0) a = -a;
        a = (a * longint'(b)) >> 6;
        if (a > 64'hFFFFFF) a = 64'hFFFFFF;
        return a[23:0];
    endfunction

    task automatic t_reset();
        logic [31:0] d;
        logic err;
        reg_rd(`PMR_OFS_CONFIG, d);
        chk("config reset", 32'h0000008A, d);
        chk("range pin reset", 32'h0, {31'h0, narrow});
        apb(1'b0, 8'h24, 32'h0, d, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, d);
    endtask

    task automatic t_range();
        logic [31:0] d;
        reg_wr(`PMR_OFS_CONFIG, 32'h81);
        chk("range pin narrow", 32'h1, {31'h0, narrow});
        reg_rd(`PMR_OFS_CONFIG, d);
        chk("config readback", 32'h81, d);
        reg_wr(`PMR_OFS_CONFIG, 32'h80);
        chk("range pin wide", 32'h0, {31'h0, narrow});
    endtask

    // Settle on fresh samples, then read every result register
    task automatic t_result(input logic [7:0] cfg, input logic [15:0] s,
                            input logic [14:0] b, input logic [11:0] tp,
                            input logic [15:0] cal);
        logic [31:0] d;
        logic [15:0] cur;
        realtime t;
        cur = exp_cur(s, cal);
        // Stop, clear a stale flag, then restart on fresh samples only
        reg_wr(`PMR_OFS_CONFIG, 32'h0);
        reg_wr(`PMR_OFS_CAL, {16'h0, cal});
        adc_shunt <= s;
        adc_bus <= b;
        adc_temp <= tp;
        reg_rd(`PMR_OFS_STATUS, d);
        reg_wr(`PMR_OFS_CONFIG, {24'h0, cfg});
        wait_flag(t);
        reg_rd(`PMR_OFS_SHUNT, d);
        chk("shunt result", {16'h0, s}, d);
        reg_rd(`PMR_OFS_BUS, d);
        chk("bus result", {17'h0, b}, d);
        reg_rd(`PMR_OFS_TEMP, d);
        chk("temperature result", {20'h0, tp}, d);
        reg_rd(`PMR_OFS_CURRENT, d);
        chk("current result", {16'h0, cur}, d);
        reg_rd(`PMR_OFS_POWER, d);
        chk("power result", {8'h0, exp_pwr(cur, b)}, d);
    endtask

    task automatic t_period(input logic [7:0] cfg, input int cyc);
        realtime t0, t1, t2;
        reg_wr(`PMR_OFS_CONFIG, {24'h0, cfg});
        wait_flag(t0);
        wait_flag(t1);
        wait_flag(t2);
        chk_near("sample period", cyc, int'((t2 - t1) / 10.0));
    endtask

    // Stopped converter: results must not move, RO write ignored
    task automatic t_hold(input logic [15:0] s);
        logic [31:0] d;
        reg_wr(`PMR_OFS_CONFIG, 32'h00);
        adc_shunt <= ~s;
        repeat (120) @(posedge clk_sys);
        reg_wr(`PMR_OFS_SHUNT, 32'h0000A5A5);
        reg_rd(`PMR_OFS_SHUNT, d);
        chk("held shunt", {16'h0, s}, d);
    endtask

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        adc_shunt = 16'h0;
        adc_bus = 15'h0;
        adc_temp = 12'h0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_range();
        t_result(8'h80, 16'h1234, 15'h1F40, 12'h0C8, 16'h1000);
        t_result(8'h81, 16'h8000, 15'h7FFF, 12'h800, 16'h4000);
        t_result(8'h80, 16'hFFF0, 15'h0100, 12'h7FF, 16'h0000);
        t_result(8'h90, 16'hFF38, 15'h2000, 12'hF38, 16'h0800);
        for (int k = 0; k < 8; k++)
            t_period(8'h80 | 8'(k << 1), ct_us[k]);
        t_period(8'h90, 200);
        t_hold(16'hFF38);
        close_out();
    end
endmodule
